// ---- dv/fsps_sequencer_test.sv ----
// Self-checking bench for the flash self-program sequencer.
// Assumes the sequencer alone, driven through its register port and processor pins.
`timescale 1ns/1ps
module fsps_sequencer_test;
    localparam int SETTLE = 20;
    // Wait after halt release before a command, as a crystal or external clock needs.
    localparam int CMD_WAIT = 8 * fsps_pkg::CLK_MHZ;
    // Design ports.
    logic       ref_clk_in;
    logic       rst_b_in;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in;
    logic       reg_write_in;
    logic       reg_read_in;
    logic [7:0] reg_rdata_out;
    logic       cpu_halt_in;
    logic       cpu_stall_out;
    logic       halt_release_out;
    logic       irq_block_out;
    logic       pin_hold_out;
    logic       self_prog_mode_out;
    // Bench state.
    int         error_cnt;
    int         num_checks;
    int         cnt;
    logic [7:0] rd;
    logic [4:0] blk;
    logic [7:0] dat;
    logic [7:0] woff;

    fsps_sequencer #(.SETTLE(SETTLE)) i_dut (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .cpu_halt_in(cpu_halt_in), .cpu_stall_out(cpu_stall_out),
        .halt_release_out(halt_release_out), .irq_block_out(irq_block_out),
        .pin_hold_out(pin_hold_out), .self_prog_mode_out(self_prog_mode_out));

    // Free-running 100 MHz clock.
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // Programming only ever clears bits of a byte.
    function automatic logic [7:0] exp_write(input logic [7:0] old, input logic [7:0] nv);
        return old & nv;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compares a byte result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares a flag result.
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_write_in <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask

    // Issues a command; stall is checked when want is 0 or 1, then the bench waits for idle.
    task automatic run_cmd(input logic [7:0] code, input int want);
        int n;
        wr(fsps_pkg::ADDR_CMD, code);
        #1;
        if (want < 2) chk1(cpu_stall_out, want[0]);
        n = 0;
        while (cpu_stall_out !== 1'b0 && n < 2000) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            $display("[ERR] %0t command never finished", $time);
            finish_test();
        end
    endtask

    // Points at a block with the given low compare value.
    task automatic set_block(input logic [4:0] b, input logic [7:0] lo);
        wr(fsps_pkg::ADDR_PTR_HIGH, {3'b000, b});
        wr(fsps_pkg::ADDR_CMP_HIGH, {3'b000, b});
        wr(fsps_pkg::ADDR_CMP_LOW, lo);
        wr(fsps_pkg::ADDR_PTR_LOW, 8'h00);
    endtask

    // Byte read and byte write at block b, offset o.
    task automatic read_byte(input logic [4:0] b, input logic [7:0] o, output logic [7:0] d);
        wr(fsps_pkg::ADDR_PTR_HIGH, {3'b000, b});
        wr(fsps_pkg::ADDR_PTR_LOW, o);
        run_cmd(fsps_pkg::CMD_BYTE_READ, 2);
        reg_rd(fsps_pkg::ADDR_READ_DATA, d);
    endtask
    task automatic write_byte(input logic [4:0] b, input logic [7:0] o, input logic [7:0] d);
        wr(fsps_pkg::ADDR_PTR_HIGH, {3'b000, b});
        wr(fsps_pkg::ADDR_PTR_LOW, o);
        wr(fsps_pkg::ADDR_WRITE_DATA, d);
        run_cmd(fsps_pkg::CMD_BYTE_WRITE, 2);
    endtask

    // Main sequence.
    initial begin
        {rst_b_in, reg_write_in, reg_read_in, cpu_halt_in} = 4'h0;
        reg_addr_in  = 4'h0;
        reg_wdata_in = 8'h00;
        error_cnt    = 0;
        num_checks   = 0;
        void'($urandom(32'h4b08_8835));
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk8(rd, 8'h00);
        reg_rd(4'hf, rd);
        chk8(rd, 8'h00);
        run_cmd(fsps_pkg::CMD_BLOCK_ERASE, 0);
        wr(fsps_pkg::ADDR_CMD, fsps_pkg::CMD_NONE);
        wr(fsps_pkg::ADDR_MODE_CTRL, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk1(self_prog_mode_out, 1'b1);
        chk1(irq_block_out, 1'b1);
        chk1(pin_hold_out, 1'b1);
        @(posedge ref_clk_in);
        cpu_halt_in <= 1'b1;
        cnt = 0;
        while (halt_release_out !== 1'b1 && cnt < SETTLE + 10) begin
            @(posedge ref_clk_in);
            #1;
            cnt++;
        end
        if (cnt >= SETTLE + 10) begin
            error_cnt++;
            $display("[ERR] %0t halt never released", $time);
            finish_test();
        end
        chk1(cnt >= SETTLE - 2 && cnt <= SETTLE + 2, 1'b1);
        @(posedge ref_clk_in);
        cpu_halt_in <= 1'b0;
        #1;
        chk1(halt_release_out, 1'b0);
        repeat (CMD_WAIT) @(posedge ref_clk_in);
        // Block 0 holds the mode-switch code, so it is never erased or written.
        blk = 5'($urandom_range(31, 1));
        set_block(blk, fsps_pkg::BYTE_ZERO);
        run_cmd(fsps_pkg::CMD_BLOCK_ERASE, 1);
        foreach (woff[i]) begin
            read_byte(blk, (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom()), rd);
            chk8(rd, fsps_pkg::BYTE_ERASED);
        end
        set_block(blk, fsps_pkg::BYTE_ERASED);
        run_cmd(fsps_pkg::CMD_BLANK_CHECK, 1);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_FAIL_BIT], 1'b0);
        for (int i = 0; i < 4; i++) begin
            woff = {i[1:0], 6'($urandom())};
            dat  = 8'($urandom()) & 8'hef;
            write_byte(blk, woff, dat);
            read_byte(blk, woff, rd);
            chk8(rd, exp_write(fsps_pkg::BYTE_ERASED, dat));
        end
        write_byte(blk, woff, dat | 8'h10);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_FAIL_BIT], 1'b1);
        read_byte(blk, woff, rd);
        chk8(rd, exp_write(dat, dat | 8'h10));
        set_block(blk, fsps_pkg::BYTE_ERASED);
        run_cmd(fsps_pkg::CMD_BLANK_CHECK, 1);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_FAIL_BIT], 1'b1);
        run_cmd(fsps_pkg::CMD_VERIFY, 1);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_FAIL_BIT], 1'b0);
        wr(fsps_pkg::ADDR_PROTECT, fsps_pkg::PROTECT_SET);
        set_block(blk, fsps_pkg::BYTE_ZERO);
        run_cmd(fsps_pkg::CMD_BLOCK_ERASE, 0);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_PROT_ERR_BIT], 1'b1);
        @(posedge ref_clk_in);
        #1;
        chk8(reg_rdata_out, 8'h00);
        read_byte(blk, woff, rd);
        chk8(rd, dat);
        wr(fsps_pkg::ADDR_STATUS, 8'h00);
        reg_rd(fsps_pkg::ADDR_STATUS, rd);
        chk1(rd[fsps_pkg::STAT_PROT_ERR_BIT], 1'b0);
        wr(fsps_pkg::ADDR_PROTECT, 8'h00);
        wr(fsps_pkg::ADDR_CMD, fsps_pkg::CMD_NONE);
        wr(fsps_pkg::ADDR_MODE_CTRL, 8'h00);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk1(self_prog_mode_out, 1'b0);
        chk1(irq_block_out, 1'b0);
        chk1(pin_hold_out, 1'b0);
        finish_test();
    end
endmodule

// ---- rtl/fsps_pkg.sv ----
// Constants, register map and command codes of the flash self-program sequencer.
// Assumes one 100 MHz clock and a plain register port with one-cycle strobes.
// What this block does
// - In self-program mode, commands run whatever the external security settings say.
// - A set protect byte makes the device refuse writes and erases.
// - After entry, the halt is released within 10 us plus two clocks.
// - No interrupt is serviced in self-program mode; irq_block_out blocks them while the mode is on.
// - After block erase every byte of the block reads all ones.
// - The processor is stalled while a command executes.
// - In self-program mode all pins hold their halt standby state.
package fsps_pkg;
    // Register indexes on the register port.
    localparam logic [3:0] ADDR_PTR_LOW      = 4'h0;
    localparam logic [3:0] ADDR_PTR_HIGH     = 4'h1;
    localparam logic [3:0] ADDR_CMP_LOW      = 4'h2;
    localparam logic [3:0] ADDR_CMP_HIGH     = 4'h3;
    localparam logic [3:0] ADDR_CMD          = 4'h4;
    localparam logic [3:0] ADDR_MODE_CTRL    = 4'h5;
    localparam logic [3:0] ADDR_PROTECT      = 4'h6;
    localparam logic [3:0] ADDR_STATUS       = 4'h7;
    localparam logic [3:0] ADDR_WRITE_DATA   = 4'h8;
    localparam logic [3:0] ADDR_READ_DATA    = 4'h9;
    // Command codes.
    localparam logic [7:0] CMD_NONE          = 8'h00;
    localparam logic [7:0] CMD_VERIFY        = 8'h01;
    localparam logic [7:0] CMD_BLANK_CHECK   = 8'h02;
    localparam logic [7:0] CMD_BLOCK_ERASE   = 8'h03;
    localparam logic [7:0] CMD_BYTE_WRITE    = 8'h04;
    localparam logic [7:0] CMD_BYTE_READ     = 8'h05;
    // Field positions and constant values.
    localparam int         MODE_ENABLE_BIT   = 0;
    localparam int         STAT_PROT_ERR_BIT = 0;
    localparam int         STAT_FAIL_BIT     = 1;
    localparam int         STAT_BUSY_BIT     = 2;
    localparam int         HIGH_PTR_BITS     = 5;
    localparam logic [7:0] PROTECT_SET       = 8'h01;
    localparam logic [7:0] BYTE_ERASED       = 8'hff;
    localparam logic [7:0] BYTE_ZERO         = 8'h00;
    // Halt settling: 10 us at 100 MHz plus two processor clocks.
    localparam int         CLK_MHZ           = 100;
    localparam int         SETTLE_US         = 10;
    localparam int         SETTLE_EXTRA      = 2;
    localparam int         SETTLE_CYCLES     = SETTLE_US * CLK_MHZ + SETTLE_EXTRA;
endpackage

// ---- rtl/fsps_sequencer.sv ----
// Flash self-program sequencer with its own small flash array.
// Assumes the processor stalls on cpu_stall_out and holds pins on pin_hold_out.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module fsps_sequencer #(
    parameter int ADDR_W = 13,
    parameter int BLOCK_W = 8,
    parameter int SETTLE = fsps_pkg::SETTLE_CYCLES
) (
    // Clock and reset.
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    // Register port.
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    // Processor control.
    input  wire logic       cpu_halt_in,
    output logic            cpu_stall_out,
    output logic            halt_release_out,
    output logic            irq_block_out,
    output logic            pin_hold_out,
    output logic            self_prog_mode_out
);
    localparam int DEPTH = 1 << ADDR_W;
    typedef enum logic [2:0] {
        FSPS_IDLE, FSPS_RUN_BLOCK, FSPS_WRITE, FSPS_READ, FSPS_DONE
    } fsps_state_type;

    logic [7:0]         array_mem [DEPTH];
    logic [7:0]         addr_pointer_low;
    logic [7:0]         addr_pointer_high;
    logic [7:0]         addr_compare_low;
    logic [7:0]         addr_compare_high;
    logic [7:0]         flash_command_reg;
    logic [7:0]         program_mode_control;
    logic [7:0]         protect_command_reg;
    logic [7:0]         write_data;
    logic [7:0]         read_data;
    logic               protect_error_flag;
    logic               fail_flag;
    fsps_state_type     state;
    logic [ADDR_W-1:0]  walk_addr;
    logic [15:0]        settle_cnt;
    logic               settling;
    logic               mode_on;
    logic               cmd_go;
    logic               is_modify;
    logic               refused;
    logic               set_prot_err;
    logic               block_last;

    // Full byte address from the two pointers; upper high bits are ignored.
    function automatic logic [ADDR_W-1:0] join_addr(input logic [7:0] hi, input logic [7:0] lo);
        join_addr = ADDR_W'({hi[fsps_pkg::HIGH_PTR_BITS-1:0], lo});
    endfunction

    assign mode_on = program_mode_control[fsps_pkg::MODE_ENABLE_BIT];
    assign cmd_go = reg_write_in && reg_addr_in == fsps_pkg::ADDR_CMD && mode_on
                    && state == FSPS_IDLE && reg_wdata_in != fsps_pkg::CMD_NONE;
    assign is_modify = reg_wdata_in == fsps_pkg::CMD_BLOCK_ERASE
                       || reg_wdata_in == fsps_pkg::CMD_BYTE_WRITE;
    // External security settings play no part; only the protect byte refuses.
    assign refused = protect_command_reg == fsps_pkg::PROTECT_SET;
    assign set_prot_err = cmd_go && is_modify && refused;
    assign block_last = &walk_addr[BLOCK_W-1:0];

    // Register writes from software.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_pointer_low     <= 8'h00;
            addr_pointer_high    <= 8'h00;
            addr_compare_low     <= 8'h00;
            addr_compare_high    <= 8'h00;
            program_mode_control <= 8'h00;
            protect_command_reg  <= 8'h00;
            write_data           <= 8'h00;
        end else if (reg_write_in) begin
            case (reg_addr_in)
                fsps_pkg::ADDR_PTR_LOW:    addr_pointer_low <= reg_wdata_in;
                fsps_pkg::ADDR_PTR_HIGH:   addr_pointer_high <= reg_wdata_in;
                fsps_pkg::ADDR_CMP_LOW:    addr_compare_low <= reg_wdata_in;
                fsps_pkg::ADDR_CMP_HIGH:   addr_compare_high <= reg_wdata_in;
                fsps_pkg::ADDR_MODE_CTRL:  program_mode_control <= reg_wdata_in;
                fsps_pkg::ADDR_PROTECT:    protect_command_reg <= reg_wdata_in;
                fsps_pkg::ADDR_WRITE_DATA: write_data <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Command register holds the last command written.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flash_command_reg <= 8'h00;
        end else if (reg_write_in && reg_addr_in == fsps_pkg::ADDR_CMD) begin
            flash_command_reg <= reg_wdata_in;
        end
    end

    // Command sequencer; the array is walked one byte a cycle.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state     <= FSPS_IDLE;
            walk_addr <= '0;
        end else begin
            case (state)
                FSPS_IDLE: begin
                    if (cmd_go && !set_prot_err) begin
                        case (reg_wdata_in)
                            fsps_pkg::CMD_BLOCK_ERASE,
                            fsps_pkg::CMD_VERIFY,
                            fsps_pkg::CMD_BLANK_CHECK: begin
                                state     <= FSPS_RUN_BLOCK;
                                walk_addr <= join_addr(addr_compare_high, fsps_pkg::BYTE_ZERO);
                            end
                            fsps_pkg::CMD_BYTE_WRITE: begin
                                state     <= FSPS_WRITE;
                                walk_addr <= join_addr(addr_pointer_high, addr_pointer_low);
                            end
                            fsps_pkg::CMD_BYTE_READ: begin
                                state     <= FSPS_READ;
                                walk_addr <= join_addr(addr_pointer_high, addr_pointer_low);
                            end
                            default: state <= FSPS_IDLE;
                        endcase
                    end
                end
                FSPS_RUN_BLOCK: begin
                    walk_addr <= walk_addr + ADDR_W'(1);
                    if (block_last) begin
                        state <= FSPS_DONE;
                    end
                end
                FSPS_WRITE: state <= FSPS_DONE;
                FSPS_READ:  state <= FSPS_DONE;
                FSPS_DONE:  state <= FSPS_IDLE;
                default:    state <= FSPS_IDLE;
            endcase
        end
    end

    // Array update: erase fills with ones, a byte write can only clear bits.
    always_ff @(posedge ref_clk_in) begin
        if (state == FSPS_RUN_BLOCK && flash_command_reg == fsps_pkg::CMD_BLOCK_ERASE) begin
            array_mem[walk_addr] <= fsps_pkg::BYTE_ERASED;
        end else if (state == FSPS_WRITE) begin
            array_mem[walk_addr] <= array_mem[walk_addr] & write_data;
        end
    end

    // Fail flag: blank check or write mismatch (verify never sets it); cleared at each new command.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fail_flag <= 1'b0;
            read_data <= 8'h00;
        end else if (cmd_go) begin
            fail_flag <= 1'b0;
        end else if (state == FSPS_RUN_BLOCK) begin
            if (flash_command_reg != fsps_pkg::CMD_BLOCK_ERASE
                && array_mem[walk_addr] != fsps_pkg::BYTE_ERASED
                && flash_command_reg == fsps_pkg::CMD_BLANK_CHECK) begin
                fail_flag <= 1'b1;
            end
        end else if (state == FSPS_WRITE) begin
            if ((array_mem[walk_addr] & write_data) != write_data) begin
                fail_flag <= 1'b1;
            end
        end else if (state == FSPS_READ) begin
            read_data <= array_mem[walk_addr];
        end
    end

    // Protect-error flag is sticky; a new refusal wins over a software clear.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            protect_error_flag <= 1'b0;
        end else if (set_prot_err) begin
            protect_error_flag <= 1'b1;
        end else if (reg_write_in && reg_addr_in == fsps_pkg::ADDR_STATUS
                     && !reg_wdata_in[fsps_pkg::STAT_PROT_ERR_BIT]) begin
            protect_error_flag <= 1'b0;
        end
    end

    // Halt settling timer started by a halt in self-program mode.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            settling         <= 1'b0;
            settle_cnt       <= 16'h0000;
            halt_release_out <= 1'b0;
        end else begin
            halt_release_out <= 1'b0;
            if (!settling && cpu_halt_in && mode_on && !halt_release_out) begin
                settling   <= 1'b1;
                settle_cnt <= 16'h0000;
            end else if (settling) begin
                settle_cnt <= settle_cnt + 16'h0001;
                if (settle_cnt == 16'(SETTLE - 2)) begin
                    settling         <= 1'b0;
                    halt_release_out <= 1'b1;
                end
            end
        end
    end

    // Processor-facing levels.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpu_stall_out      <= 1'b0;
            irq_block_out      <= 1'b0;
            pin_hold_out       <= 1'b0;
            self_prog_mode_out <= 1'b0;
        end else begin
            cpu_stall_out      <= cmd_go ? !set_prot_err
                                  : (state != FSPS_IDLE && state != FSPS_DONE);
            irq_block_out      <= mode_on;
            pin_hold_out       <= mode_on;
            self_prog_mode_out <= mode_on;
        end
    end

    // Read data one cycle after the read strobe.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                fsps_pkg::ADDR_PTR_LOW:    reg_rdata_out <= addr_pointer_low;
                fsps_pkg::ADDR_PTR_HIGH:   reg_rdata_out <= addr_pointer_high;
                fsps_pkg::ADDR_CMP_LOW:    reg_rdata_out <= addr_compare_low;
                fsps_pkg::ADDR_CMP_HIGH:   reg_rdata_out <= addr_compare_high;
                fsps_pkg::ADDR_CMD:        reg_rdata_out <= flash_command_reg;
                fsps_pkg::ADDR_MODE_CTRL:  reg_rdata_out <= program_mode_control;
                fsps_pkg::ADDR_PROTECT:    reg_rdata_out <= protect_command_reg;
                fsps_pkg::ADDR_STATUS:     reg_rdata_out <= {5'b0_0000, state != FSPS_IDLE,
                                                             fail_flag, protect_error_flag};
                fsps_pkg::ADDR_WRITE_DATA: reg_rdata_out <= write_data;
                fsps_pkg::ADDR_READ_DATA:  reg_rdata_out <= read_data;
                default:                   reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Checks on the sequencer.
    a_prot_err_set: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        set_prot_err |=> protect_error_flag) else $error("protect error not flagged");
    a_prot_no_run: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        set_prot_err |=> state == FSPS_IDLE) else $error("protected command ran");
    a_stall_busy: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state == FSPS_RUN_BLOCK) |-> cpu_stall_out) else $error("no stall while busy");
    a_erase_ones: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state == FSPS_RUN_BLOCK && flash_command_reg == fsps_pkg::CMD_BLOCK_ERASE)
        |=> array_mem[$past(walk_addr)] == fsps_pkg::BYTE_ERASED)
        else $error("erased byte not all ones");
    // Helper count of cycles spent settling, so the release bound needs no long delay range.
    logic [15:0] settle_seen;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            settle_seen <= 16'h0000;
        end else if (settling) begin
            settle_seen <= settle_seen + 16'h0001;
        end else begin
            settle_seen <= 16'h0000;
        end
    end
    a_settle_time: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        settling |-> settle_seen < 16'(SETTLE)) else $error("halt not released");
    a_irq_block: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        mode_on |=> irq_block_out) else $error("interrupts not blocked");
    a_pin_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        mode_on |=> pin_hold_out) else $error("pins not held");
    a_no_security: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_go && !refused) |=> state != FSPS_IDLE) else $error("command not accepted");
    c_erase: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state == FSPS_RUN_BLOCK && flash_command_reg == fsps_pkg::CMD_BLOCK_ERASE);
    c_write: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state == FSPS_WRITE);
    c_refuse: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) set_prot_err);
    c_release: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) halt_release_out);
endmodule
